// ### common/amp_ctrl_pkg.sv
`default_nettype none
package amp_ctrl_pkg;
	// Register byte addresses on the serial control interface
	localparam logic [7:0] LEFT_GAIN_ADDR = 8'h00;
	localparam logic [7:0] RIGHT_GAIN_ADDR = 8'h01;
	localparam logic [7:0] MODE_SETTINGS_ADDR = 8'h02;
	localparam logic [7:0] ATTACK_RELEASE_ADDR = 8'h03;
	localparam logic [7:0] LEVEL_CONFIG_ADDR = 8'h04;
	localparam logic [7:0] SOFT_RESET_ADDR = 8'h08;

	// Field positions
	localparam int EDGE_POS = 4;
	localparam int OC_REC_POS = 3;
	localparam int OT_REC_POS = 2;
	localparam int R2B_POS = 1;
	localparam int L2B_POS = 0;
	localparam int RELEASE_POS = 3;
	localparam int ATTACK_POS = 0;
	localparam int LEVEL_EN_POS = 7;
	localparam int COMP_POS = 5;
	localparam int THR_MODE_POS = 4;
	localparam int THR_LEVEL_POS = 0;

	// Reset values
	localparam logic [1:0] EDGE_RST = 2'h0;
	localparam logic OC_REC_RST = 1'b1;
	localparam logic OT_REC_RST = 1'b1;
	localparam logic MIX_RST = 1'b0;
	localparam logic [2:0] RELEASE_RST = 3'h5;
	localparam logic [2:0] ATTACK_RST = 3'h3;
	localparam logic LEVEL_EN_RST = 1'b0;
	localparam logic [1:0] COMP_RST = 2'h2;
	localparam logic THR_MODE_RST = 1'b0;
	localparam logic [3:0] THR_LEVEL_RST = 4'hb;
	localparam logic [5:0] GAIN_RST = 6'h22;

	// Step timing: shortest step of each kind, doubled per code step
	localparam int CLK_PERIOD_NS = 20;
	localparam int ATTACK_STEP_NS = 32000;
	localparam int RELEASE_STEP_NS = 4000000;
	localparam int ATTACK_BASE_CYCLES = ATTACK_STEP_NS / CLK_PERIOD_NS;
	localparam int RELEASE_BASE_CYCLES = RELEASE_STEP_NS / CLK_PERIOD_NS;

	// Arbitrary default 7-bit bus address of this device
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h31;

	typedef struct packed {
		logic [1:0] edge_rate;
		logic overcurrent_auto_recover;
		logic overtemp_auto_recover;
		logic right_to_both_mix;
		logic left_to_both_mix;
	} mode_cfg_t;

	typedef struct packed {
		logic [2:0] release_step_time;
		logic [2:0] attack_step_time;
		logic level_control_enable;
		logic [1:0] compressor_curve;
		logic threshold_mode_select;
		logic [3:0] limiter_threshold_level;
	} level_cfg_t;
endpackage : amp_ctrl_pkg
`default_nettype wire

// ### verilog/amp_mode_and_level_control_regs.sv
`default_nettype none
// Summary of operation
// [RULE1] A two-bit edge rate field selects normal edges at code 00 (reset) or one of three slow edge variants.
// [RULE2] Setting the right mix bit sends the right input to both outputs; it resets to off.
// [RULE3] Setting the left mix bit sends the left input to both outputs; it resets to off.
// [RULE4] The three-bit release field sets 4 ms per step at 000, doubling per code to 512 ms, reset 101.
// [RULE5] The three-bit attack field sets 32 us per step at 000, doubling per code to 4 ms, reset 011.
// [RULE6] The level control enable bit hands gain to automatic control when 1 and resets to 0.
// [RULE7] The two-bit compressor field picks limiter, mode one, mode two (reset) or mode three.
// [RULE8] The threshold mode bit picks supply tracking at 0 (reset) or fixed power at 1.
// [RULE9] A four-bit threshold level code picks one of sixteen thresholds and resets to 1011.
// [RULE10] While automatic level control is on, writes to both gain fields are ignored.
// [RULE11] While automatic level control is on, the left gain drives both channels.
// [RULE12] Both fault autorecovery bits reset to 1 and writing 0 turns recovery off.
// [RULE13] Unused upper bits of the mode and attack/release registers read zero and ignore writes.
module amp_mode_and_level_control_regs #(
	parameter logic [6:0] DEV_ADDR = amp_ctrl_pkg::DEV_ADDR_DEFAULT,
	parameter int ATTACK_BASE = amp_ctrl_pkg::ATTACK_BASE_CYCLES,
	parameter int RELEASE_BASE = amp_ctrl_pkg::RELEASE_BASE_CYCLES
) (
	input wire logic I_CLK, // 50 MHz system clock
	input wire logic I_RST, // Asynchronous reset, active high
	input wire logic I_SCL, // Serial clock pin
	input wire logic I_SDA, // Serial data pin, input side
	output logic O_SDA_OUT, // Serial data output level, always low
	output logic O_SDA_OE, // High while pulling serial data low
	output amp_ctrl_pkg::mode_cfg_t O_MODE, // Amplifier mode settings
	output amp_ctrl_pkg::level_cfg_t O_LEVEL, // Level control settings
	output logic [5:0] O_LEFT_GAIN, // Gain applied to left channel
	output logic [5:0] O_RIGHT_GAIN, // Gain applied to right channel
	output logic O_ATTACK_STEP, // One-cycle pulse per attack step
	output logic O_RELEASE_STEP // One-cycle pulse per release step
);
	import amp_ctrl_pkg::*;

	generate
		if (ATTACK_BASE < 1 || RELEASE_BASE < 1 || RELEASE_BASE > 2000000) begin : g_bad_param
			$error("step base counts out of range");
		end
	endgenerate

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WR, S_WR_ACK, S_RD, S_MST_ACK
	} bus_state_t;

	bus_state_t state;
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl_rise, scl_fall, start_cond, stop_cond;
	logic [7:0] shreg;
	logic [7:0] txreg;
	logic [3:0] bitcnt;
	logic [7:0] ptr;
	logic read_dir;
	logic mst_nack;
	logic wr_pulse;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	mode_cfg_t mode;
	level_cfg_t level;
	logic [5:0] left_gain;
	logic [5:0] right_gain;
	logic [31:0] attack_cnt;
	logic [31:0] release_cnt;
	logic [31:0] attack_limit;
	logic [31:0] release_limit;
	logic [7:0] rd_byte;

	// Register read mux, shared by the first byte and every auto-incremented byte
	function automatic logic [7:0] read_reg(input logic [7:0] a, input mode_cfg_t m, input level_cfg_t l,
			input logic [5:0] lg, input logic [5:0] rg);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			LEFT_GAIN_ADDR: d = {2'h0, lg};
			RIGHT_GAIN_ADDR: d = {2'h0, rg};
			MODE_SETTINGS_ADDR: d = {2'h0, m}; // RULE13
			ATTACK_RELEASE_ADDR: d = {2'h0, l.release_step_time, l.attack_step_time}; // RULE13
			LEVEL_CONFIG_ADDR: d = {l.level_control_enable, l.compressor_curve, l.threshold_mode_select,
				l.limiter_threshold_level};
			default: d = 8'h00;
		endcase
		return d;
	endfunction : read_reg

	// Byte at the pointer; a named net because a function result cannot be bit-selected
	assign rd_byte = read_reg(ptr, mode, level, left_gain, right_gain);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 0 feeds only stage 1, stage 2 is kept for edges
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end else begin
			scl_sync <= {scl_sync[1:0], I_SCL};
			sda_sync <= {sda_sync[1:0], I_SDA};
		end
	end

	// Bus events seen on the synchronised pins
	assign scl_rise = scl_sync[1] & ~scl_sync[2];
	assign scl_fall = ~scl_sync[1] & scl_sync[2];
	assign start_cond = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign stop_cond = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

	////////////////////////////////////////////////////////////////////////////
	// Serial slave: shift on rising clock, drive data only after falling clock
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state <= S_IDLE;
			shreg <= 8'h00;
			txreg <= 8'h00;
			bitcnt <= 4'h0;
			ptr <= 8'h00;
			read_dir <= 1'b0;
			mst_nack <= 1'b1;
			O_SDA_OE <= 1'b0;
			wr_pulse <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			wr_pulse <= 1'b0;
			if (start_cond) begin
				state <= S_ADDR;
				bitcnt <= 4'h0;
				O_SDA_OE <= 1'b0;
			end else if (stop_cond) begin
				state <= S_IDLE;
				O_SDA_OE <= 1'b0;
			end else if (scl_rise) begin
				if (state == S_ADDR || state == S_PTR || state == S_WR) begin
					shreg <= {shreg[6:0], sda_sync[1]};
					bitcnt <= bitcnt + 4'h1;
				end else if (state == S_RD) begin
					bitcnt <= bitcnt + 4'h1;
				end else if (state == S_MST_ACK) begin
					mst_nack <= sda_sync[1];
				end
			end else if (scl_fall) begin
				unique case (state)
					S_IDLE: O_SDA_OE <= 1'b0;
					S_ADDR: if (bitcnt == 4'h8) begin
						// Foreign address: stay off the bus until the next start
						if (shreg[7:1] == DEV_ADDR) begin
							state <= S_ADDR_ACK;
							read_dir <= shreg[0];
							O_SDA_OE <= 1'b1;
						end else begin
							state <= S_IDLE;
						end
					end
					S_ADDR_ACK: begin
						bitcnt <= 4'h0;
						if (read_dir) begin
							state <= S_RD;
							txreg <= rd_byte;
							O_SDA_OE <= ~rd_byte[7];
							ptr <= ptr + 8'h01;
						end else begin
							state <= S_PTR;
							O_SDA_OE <= 1'b0;
						end
					end
					S_PTR: if (bitcnt == 4'h8) begin
						ptr <= shreg;
						state <= S_PTR_ACK;
						O_SDA_OE <= 1'b1;
					end
					S_WR: if (bitcnt == 4'h8) begin
						wr_pulse <= 1'b1;
						wr_addr <= ptr;
						wr_data <= shreg;
						ptr <= ptr + 8'h01;
						state <= S_WR_ACK;
						O_SDA_OE <= 1'b1;
					end
					S_PTR_ACK, S_WR_ACK: begin
						state <= S_WR;
						bitcnt <= 4'h0;
						O_SDA_OE <= 1'b0;
					end
					S_RD: if (bitcnt == 4'h8) begin
						state <= S_MST_ACK;
						O_SDA_OE <= 1'b0;
					end else begin
						O_SDA_OE <= ~txreg[6];
						txreg <= {txreg[6:0], 1'b0};
					end
					S_MST_ACK: if (mst_nack) begin
						state <= S_IDLE;
					end else begin
						state <= S_RD;
						bitcnt <= 4'h0;
						txreg <= rd_byte;
						O_SDA_OE <= ~rd_byte[7];
						ptr <= ptr + 8'h01;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode and level registers; the soft reset address restores every default
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			mode.edge_rate <= EDGE_RST; // RULE1
			mode.overcurrent_auto_recover <= OC_REC_RST; // RULE12
			mode.overtemp_auto_recover <= OT_REC_RST; // RULE12
			mode.right_to_both_mix <= MIX_RST; // RULE2
			mode.left_to_both_mix <= MIX_RST; // RULE3
			level.release_step_time <= RELEASE_RST; // RULE4
			level.attack_step_time <= ATTACK_RST; // RULE5
			level.level_control_enable <= LEVEL_EN_RST; // RULE6
			level.compressor_curve <= COMP_RST; // RULE7
			level.threshold_mode_select <= THR_MODE_RST; // RULE8
			level.limiter_threshold_level <= THR_LEVEL_RST; // RULE9
			left_gain <= GAIN_RST;
			right_gain <= GAIN_RST;
		end else if (wr_pulse) begin
			unique case (wr_addr)
				MODE_SETTINGS_ADDR: begin
					// Bits 7:6 are dropped here so they can never be stored
					mode.edge_rate <= wr_data[EDGE_POS +: 2]; // RULE1
					mode.overcurrent_auto_recover <= wr_data[OC_REC_POS]; // RULE12
					mode.overtemp_auto_recover <= wr_data[OT_REC_POS]; // RULE12
					mode.right_to_both_mix <= wr_data[R2B_POS]; // RULE2
					mode.left_to_both_mix <= wr_data[L2B_POS]; // RULE3
				end
				ATTACK_RELEASE_ADDR: begin
					level.release_step_time <= wr_data[RELEASE_POS +: 3]; // RULE4 RULE13
					level.attack_step_time <= wr_data[ATTACK_POS +: 3]; // RULE5 RULE13
				end
				LEVEL_CONFIG_ADDR: begin
					level.level_control_enable <= wr_data[LEVEL_EN_POS]; // RULE6
					level.compressor_curve <= wr_data[COMP_POS +: 2]; // RULE7
					level.threshold_mode_select <= wr_data[THR_MODE_POS]; // RULE8
					level.limiter_threshold_level <= wr_data[THR_LEVEL_POS +: 4]; // RULE9
				end
				LEFT_GAIN_ADDR: if (!level.level_control_enable) begin
					left_gain <= wr_data[5:0]; // RULE10
				end
				RIGHT_GAIN_ADDR: if (!level.level_control_enable) begin
					right_gain <= wr_data[5:0]; // RULE10
				end
				SOFT_RESET_ADDR: begin
					mode <= {EDGE_RST, OC_REC_RST, OT_REC_RST, MIX_RST, MIX_RST};
					level <= {RELEASE_RST, ATTACK_RST, LEVEL_EN_RST, COMP_RST, THR_MODE_RST, THR_LEVEL_RST};
					left_gain <= GAIN_RST;
					right_gain <= GAIN_RST;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered outputs; under level control the left gain drives both sides
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_SDA_OUT <= 1'b0;
			O_MODE <= '0;
			O_LEVEL <= '0;
			O_LEFT_GAIN <= 6'h00;
			O_RIGHT_GAIN <= 6'h00;
		end else begin
			O_SDA_OUT <= 1'b0;
			O_MODE <= mode;
			O_LEVEL <= level;
			O_LEFT_GAIN <= left_gain;
			O_RIGHT_GAIN <= level.level_control_enable ? left_gain : right_gain; // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step timers: base period doubled once per code step, idle while disabled
	assign attack_limit = 32'(ATTACK_BASE) << level.attack_step_time; // RULE5
	assign release_limit = 32'(RELEASE_BASE) << level.release_step_time; // RULE4

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			attack_cnt <= 32'h0;
			O_ATTACK_STEP <= 1'b0;
		end else if (!level.level_control_enable || attack_cnt >= attack_limit - 32'h1) begin
			// Compare with >= so a shorter code written mid-count takes effect at once
			attack_cnt <= 32'h0;
			O_ATTACK_STEP <= level.level_control_enable;
		end else begin
			attack_cnt <= attack_cnt + 32'h1;
			O_ATTACK_STEP <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			release_cnt <= 32'h0;
			O_RELEASE_STEP <= 1'b0;
		end else if (!level.level_control_enable || release_cnt >= release_limit - 32'h1) begin
			release_cnt <= 32'h0;
			O_RELEASE_STEP <= level.level_control_enable;
		end else begin
			release_cnt <= release_cnt + 32'h1;
			O_RELEASE_STEP <= 1'b0;
		end
	end
endmodule : amp_mode_and_level_control_regs
`default_nettype wire

// ### dv/amp_regs_props.sv
`default_nettype none
module amp_regs_props
	import amp_ctrl_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h31,
	parameter int ATTACK_BASE = 4,
	parameter int RELEASE_BASE = 8
) (
	input wire logic I_CLK, // Clock
	input wire logic I_RST, // Async reset
	input wire logic I_SCL, // Serial clock
	input wire logic I_SDA, // Serial data
	input wire logic O_SDA_OUT, // Data drive level
	input wire logic O_SDA_OE, // Data drive enable
	input wire amp_ctrl_pkg::mode_cfg_t O_MODE, // Mode settings
	input wire amp_ctrl_pkg::level_cfg_t O_LEVEL, // Level settings
	input wire logic [5:0] O_LEFT_GAIN, // Left gain
	input wire logic [5:0] O_RIGHT_GAIN, // Right gain
	input wire logic O_ATTACK_STEP, // Attack pulse
	input wire logic O_RELEASE_STEP // Release pulse
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	int atk_cnt;
	int rel_cnt;
	logic atk_seen;
	logic rel_seen;
	int atk_per;
	int rel_per;
	////////////////////////////////////////
	// Expected pulse spacing for the current codes
	assign atk_per = ATTACK_BASE << O_LEVEL.attack_step_time;
	assign rel_per = RELEASE_BASE << O_LEVEL.release_step_time;
	// Spacing is only judged after one clean pulse, since a code change may cut a period short
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			atk_cnt <= 0;
			atk_seen <= 1'b0;
		end else if (!O_LEVEL.level_control_enable || $changed(O_LEVEL.attack_step_time)) begin
			atk_cnt <= 0;
			atk_seen <= 1'b0;
		end else begin
			atk_cnt <= O_ATTACK_STEP ? 0 : atk_cnt + 1;
			atk_seen <= atk_seen | O_ATTACK_STEP;
		end
	end
	// Same bookkeeping for release
	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rel_cnt <= 0;
			rel_seen <= 1'b0;
		end else if (!O_LEVEL.level_control_enable || $changed(O_LEVEL.release_step_time)) begin
			rel_cnt <= 0;
			rel_seen <= 1'b0;
		end else begin
			rel_cnt <= O_RELEASE_STEP ? 0 : rel_cnt + 1;
			rel_seen <= rel_seen | O_RELEASE_STEP;
		end
	end
	////////////////////////////////////////
	// Properties
	reset_dflt_a: assert property ($fell(I_RST) |-> ##[0:2] (O_MODE == 6'h0c && O_LEVEL == 14'h2b4b))
		else $error("defaults not loaded after reset");
	// The code and enable seen here lag the design by a cycle, so the edge of a change is skipped
	atk_period_a: assert property (O_ATTACK_STEP && atk_seen && $stable(O_LEVEL.attack_step_time)
		|-> atk_cnt == atk_per - 1)
		else $error("attack pulse spacing wrong");
	atk_due_a: assert property (atk_seen && O_LEVEL.level_control_enable && $stable(O_LEVEL.attack_step_time)
		|-> atk_cnt < atk_per)
		else $error("attack pulse missing");
	rel_period_a: assert property (O_RELEASE_STEP && rel_seen && $stable(O_LEVEL.release_step_time)
		|-> rel_cnt == rel_per - 1)
		else $error("release pulse spacing wrong");
	rel_due_a: assert property (rel_seen && O_LEVEL.level_control_enable && $stable(O_LEVEL.release_step_time)
		|-> rel_cnt < rel_per)
		else $error("release pulse missing");
	step_enable_a: assert property (O_ATTACK_STEP || O_RELEASE_STEP |-> O_LEVEL.level_control_enable)
		else $error("step pulse while level control off");
	gain_track_a: assert property (O_LEVEL.level_control_enable && $past(O_LEVEL.level_control_enable)
		|-> O_RIGHT_GAIN == O_LEFT_GAIN)
		else $error("right gain not following left");
	gain_hold_a: assert property (O_LEVEL.level_control_enable [*2] |-> $stable(O_LEFT_GAIN))
		else $error("gain changed under level control");
	sda_low_a: assert property (O_SDA_OE |-> !O_SDA_OUT)
		else $error("data pin driven high");
	atk_c: cover property (O_ATTACK_STEP && atk_seen);
	rel_c: cover property (O_RELEASE_STEP && rel_seen);
	ack_c: cover property ($rose(O_SDA_OE) && O_LEVEL.level_control_enable);
endmodule : amp_regs_props
bind amp_mode_and_level_control_regs amp_regs_props #(
	.DEV_ADDR(DEV_ADDR), .ATTACK_BASE(ATTACK_BASE), .RELEASE_BASE(RELEASE_BASE)
) props_u (
	.I_CLK(I_CLK), .I_RST(I_RST), .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA_OUT(O_SDA_OUT),
	.O_SDA_OE(O_SDA_OE), .O_MODE(O_MODE), .O_LEVEL(O_LEVEL), .O_LEFT_GAIN(O_LEFT_GAIN),
	.O_RIGHT_GAIN(O_RIGHT_GAIN), .O_ATTACK_STEP(O_ATTACK_STEP), .O_RELEASE_STEP(O_RELEASE_STEP)
);
`default_nettype wire

// ### dv/amp_host_model.sv
`default_nettype none
module amp_host_model (
	input wire logic clk, // Bench clock
	input wire logic sda_in, // Resolved data wire
	output logic scl, // Serial clock
	output logic sda_drv // Data drive, 1 releases
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0] dev;
	initial scl = 1'b1;
	initial sda_drv = 1'b1;
	// One phase of 4 clocks; callers change one line at a time to keep setup and hold
	task automatic step(input logic c, input logic d);
		scl <= c;
		sda_drv <= d;
		repeat (4) @(posedge clk);
	endtask : step
	// Data goes d0 then d1 with clock high: 1,0 starts a frame, 0,1 ends it
	task automatic cond(input logic d0, input logic d1);
		step(1'b0, sda_drv);
		step(1'b0, d0);
		step(1'b1, d0);
		step(1'b1, d1);
	endtask : cond
	// Byte MSB first plus ninth bit n; q holds what the wire carried
	task automatic xfer(input logic [7:0] d, input logic n, output logic [8:0] q);
		logic [8:0] v;
		v = {d, n};
		for (int i = 8; i >= 0; i--) begin
			step(1'b0, sda_drv);
			step(1'b0, v[i]);
			step(1'b1, v[i]);
			q[i] = sda_in;
			step(1'b1, v[i]);
		end
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic [8:0] q0;
		logic [8:0] q1;
		logic [8:0] q2;
		cond(1'b1, 1'b0);
		xfer({dev, 1'b0}, 1'b1, q0);
		xfer(a, 1'b1, q1);
		xfer(d, 1'b1, q2);
		cond(1'b0, 1'b1);
		ok = !(q0[0] | q1[0] | q2[0]);
	endtask : wr
	// Pointer write, repeated start, one byte read and ended with a not-acknowledge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] q;
		cond(1'b1, 1'b0);
		xfer({dev, 1'b0}, 1'b1, q);
		xfer(a, 1'b1, q);
		cond(1'b1, 1'b0);
		xfer({dev, 1'b1}, 1'b1, q);
		xfer(8'hff, 1'b1, q);
		d = q[8:1];
		cond(1'b0, 1'b1);
	endtask : rd
endmodule : amp_host_model
`default_nettype wire

// ### dv/amp_mode_and_level_control_regs_bench.sv
`default_nettype none
module amp_mode_and_level_control_regs_bench;
	import amp_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int AB = 4;
	localparam int RB = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic scl;
	logic sda_drv;
	logic oe;
	logic so;
	logic atk;
	logic rel;
	logic [5:0] lg;
	logic [5:0] rg;
	mode_cfg_t mode;
	level_cfg_t lvl;
	wire sda;
	int failures = 0;
	int check_count = 0;
	// Pull-up wins unless someone pulls low
	assign sda = sda_drv & ~(oe & ~so);
	amp_mode_and_level_control_regs #(.ATTACK_BASE(AB), .RELEASE_BASE(RB)) dut_u (
		.I_CLK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(so), .O_SDA_OE(oe),
		.O_MODE(mode), .O_LEVEL(lvl), .O_LEFT_GAIN(lg), .O_RIGHT_GAIN(rg),
		.O_ATTACK_STEP(atk), .O_RELEASE_STEP(rel)
	);
	amp_host_model host_u (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv(sda_drv));
	initial forever #10 clk = ~clk;
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		host_u.wr(a, d, ok);
		chk(ok, 1'b1);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host_u.rd(a, d);
		chk(d, exp);
	endtask : rd_chk
	// Sampled on the falling edge, where registered outputs have settled
	task automatic next_pulse(input int r, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((r ? rel : atk) !== 1'b1 && n < 4096);
	endtask : next_pulse
	////////////////////////////////////////
	task automatic t_defaults;
		chk(mode, 6'h0c);
		chk(lvl, {3'h5, 3'h3, 1'b0, 2'h2, 1'b0, 4'hb});
		rd_chk(MODE_SETTINGS_ADDR, 8'h0c);
		rd_chk(ATTACK_RELEASE_ADDR, 8'h2b);
		rd_chk(LEVEL_CONFIG_ADDR, 8'h4b);
	endtask : t_defaults
	// Every edge code, each mode bit set and cleared, unused bits written as ones
	task automatic t_mode;
		logic [1:0] c;
		logic ok;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			wr(MODE_SETTINGS_ADDR, {2'b11, c, c, c});
			chk(mode, {c, c, c});
			rd_chk(MODE_SETTINGS_ADDR, {2'b00, c, c, c});
		end
		wr(8'h07, 8'h55);
		rd_chk(8'h07, 8'h00);
		host_u.dev = 7'h32;
		host_u.wr(MODE_SETTINGS_ADDR, 8'h00, ok);
		host_u.dev = DEV_ADDR_DEFAULT;
		chk({ok, mode}, {1'b0, 6'h3f});
	endtask : t_mode
	task automatic t_level;
		logic [2:0] c;
		logic [7:0] d;
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			d = {1'b0, c[1:0], c[2], c, ~c[0]};
			wr(ATTACK_RELEASE_ADDR, {2'b11, c, ~c});
			wr(LEVEL_CONFIG_ADDR, d);
			chk(lvl, {c, ~c, d});
			rd_chk(ATTACK_RELEASE_ADDR, {2'b00, c, ~c});
			rd_chk(LEVEL_CONFIG_ADDR, d);
		end
	endtask : t_level
	// Gains move freely until level control takes over, then lock and pair up
	task automatic t_gain;
		wr(LEFT_GAIN_ADDR, 8'hd0);
		wr(RIGHT_GAIN_ADDR, 8'h05);
		chk({lg, rg}, {6'h10, 6'h05});
		wr(LEVEL_CONFIG_ADDR, 8'h80);
		chk({lg, rg}, {6'h10, 6'h10});
		wr(LEFT_GAIN_ADDR, 8'h2a);
		wr(RIGHT_GAIN_ADDR, 8'h2a);
		chk({lg, rg}, {6'h10, 6'h10});
		rd_chk(LEFT_GAIN_ADDR, 8'h10);
		rd_chk(RIGHT_GAIN_ADDR, 8'h05);
	endtask : t_gain
	// The soft reset address brings every field back to its default
	task automatic t_soft_reset;
		wr(SOFT_RESET_ADDR, 8'h00);
		chk(mode, 6'h0c);
		chk(lvl, 14'h2b4b);
		chk({lg, rg}, {6'h22, 6'h22});
	endtask : t_soft_reset
	// The first gap after a code change is only a resync, the second is judged
	task automatic t_step;
		int n;
		for (int c = 0; c < 3; c++) begin
			wr(ATTACK_RELEASE_ADDR, 8'((c << 3) | c));
			for (int r = 0; r < 2; r++) begin
				next_pulse(r, n);
				next_pulse(r, n);
				chk(16'(n), 16'((r ? RB : AB) << c));
			end
		end
	endtask : t_step
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	initial begin
		host_u.dev = DEV_ADDR_DEFAULT;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_defaults();
		t_mode();
		t_level();
		t_gain();
		t_step();
		t_soft_reset();
		finish_test();
	end
	// The run needs about 30000 cycles; a hang is caught at the 90000-cycle budget, three times that
	initial begin
		repeat (90000) @(posedge clk);
		failures++;
		finish_test();
	end
endmodule : amp_mode_and_level_control_regs_bench
`default_nettype wire
